// >>> cmtm_regs.vh
// register map, field positions and reset values of the comms timer block
// Functional notes
// RL1: two gate pins exist, the first serving timers one and two, the second timers three and four.
// RL2: a timer tied to a gate pin is either gated by its level or restarted by its edge.
// RL3: each timer drives its own output pin when its count reaches its reference value.
// RL4: on a match the output either pulses low for one cycle or toggles its level.
// RL5: a timer output can feed another timer's input so the pair forms a 32-bit timer.
// RL6: each timer counts another timer, the system clock, the system clock over 16, or its input pin.
// RL7: four external timer input pins are provided.
// RL8: capture on a timer input fires on the rising, the falling or both edges.
// RL9: the system-integration timers default to the first baud generator, fed by clock pin five when chosen.
// RL10: with clock pin five not enabled the first baud generator runs from the internal clock.
// RL11: when the dedicated timer clock pin is chosen the baud generator path to those timers is cut.
// RL12: eight baud generators exist, each with its own output pin and usable inside the block; only the first is used inside.
// RL13: cascading pairs timer one under two and three under four, the lower clocking the upper.
// RL14: gate and input pins are synchronised to the system clock before any use.
`ifndef CMTM_REGS_VH
`define CMTM_REGS_VH
`define CMTM_GCFG_ADDR 8'h00
`define CMTM_STAT_ADDR 8'h04
`define CMTM_TMR_BASE 8'h10
`define CMTM_TMR_STRIDE 8'h10
`define CMTM_TMR_MODE_OFS 4'h0
`define CMTM_TMR_REF_OFS 4'h4
`define CMTM_TMR_CNT_OFS 4'h8
`define CMTM_TMR_CAP_OFS 4'hc
`define CMTM_BRG_BASE 8'h60
`define CMTM_BRG_END 8'h80
`define CMTM_GCFG_CASC12 0
`define CMTM_GCFG_CASC34 1
`define CMTM_GCFG_EXT_CLOCK_PIN_FIVE_EN 2
`define CMTM_GCFG_SIU_TIMER_CLOCK_PIN_SEL 3
`define CMTM_GCFG_W 4
`define CMTM_MODE_SRC_LSB 0
`define CMTM_MODE_GATE_LSB 2
`define CMTM_MODE_TOGGLE 4
`define CMTM_MODE_CAP_LSB 5
`define CMTM_MODE_EN 7
`define CMTM_MODE_W 8
`define CMTM_SRC_TIMER 2'h0
`define CMTM_SRC_SYSCLK 2'h1
`define CMTM_SRC_DIV16 2'h2
`define CMTM_SRC_PIN 2'h3
`define CMTM_GATE_NONE 2'h0
`define CMTM_GATE_LEVEL 2'h1
`define CMTM_GATE_RESTART 2'h2
`define CMTM_CAP_RISE 0
`define CMTM_CAP_FALL 1
`define CMTM_PRESCALE_MAX 4'hf
`define CMTM_REF_RESET 16'hffff
`define CMTM_BRG_DIV_RESET 12'h000
`define CMTM_RESP_OKAY 2'b00
`define CMTM_RESP_SLVERR 2'b10
`endif

// >>> cmtm_sync.v
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module cmtm_sync #(
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_r;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      // first stage read only here
      sync_out <= meta_r;
    end
  end
endmodule // cmtm_sync

// >>> cmtm_timers.v
// four gated capture timers, baud generators and timer clock select
`timescale 1ns/1ps
`include "cmtm_regs.vh"
module cmtm_timers #(
  parameter TW = 16,
  parameter NBRG = 8,
  parameter BW = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire gate_in_a,
  input wire gate_in_b,
  input wire [3:0] capture_in,
  input wire ext_clock_pin_five,
  input wire siu_timer_clock_pin,
  output reg [3:0] match_out,
  output reg [NBRG-1:0] baud_gen_out,
  output reg siu_timer_tick
);
  // pins: 0 gate a, 1 gate b, 5:2 inputs, 6 clock five, 7 timer clock
  wire [7:0] pin_s;
  reg [7:0] pin_d_r;
  wire [7:0] pin_rise;
  wire [7:0] pin_fall;

  cmtm_sync #(.W(8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({siu_timer_clock_pin, ext_clock_pin_five, capture_in, gate_in_b, gate_in_a}),
    .sync_out(pin_s)
  ); // RL14 RL7 RL1

  assign pin_rise = pin_s & ~pin_d_r;
  assign pin_fall = ~pin_s & pin_d_r;

  reg [`CMTM_GCFG_W-1:0] gcfg_r;
  reg [7:0] stat_r;
  reg [4*`CMTM_MODE_W-1:0] mode_r;
  reg [4*TW-1:0] ref_r;
  reg [4*TW-1:0] cnt_r;
  reg [4*TW-1:0] cap_r;
  reg [NBRG*BW-1:0] brg_div_r;
  reg [NBRG*BW-1:0] brg_cnt_r;
  reg [3:0] pre_r;
  reg [3:0] mev_r;
  wire [3:0] match_ev;
  wire [3:0] cap_ev;
  wire [NBRG-1:0] brg_wrap;
  wire div16_tick;

  // bus state
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg aw_have_r;
  reg w_have_r;
  wire wr_go;
  wire [7:0] wa;
  wire wa_tmr;
  wire [1:0] wa_idx;
  wire [3:0] wa_ofs;
  wire [7:0] ra;

  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wa = awaddr_r;
  assign wa_tmr = (wa >= `CMTM_TMR_BASE) && (wa < `CMTM_BRG_BASE);
  assign wa_idx = wa[5:4] - 2'h1;
  assign wa_ofs = wa[3:0];
  assign ra = s_axi_araddr;
  assign div16_tick = (pre_r == `CMTM_PRESCALE_MAX); // RL6

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_d_r <= 8'h00;
      pre_r <= 4'h0;
      mev_r <= 4'h0;
    end
    else
    begin
      pin_d_r <= pin_s;
      pre_r <= pre_r + 4'h1;
      mev_r <= match_ev;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_tmr
      wire [`CMTM_MODE_W-1:0] md;
      wire [1:0] src;
      wire [1:0] gmode;
      wire en;
      wire gate_lvl;
      wire gate_edge;
      wire casc_upper;
      wire src_tick;
      wire tick;
      wire cnt_hold;
      wire [TW-1:0] cnt;
      wire [TW-1:0] refv;
      wire wr_me;

      assign md = mode_r[i*`CMTM_MODE_W +: `CMTM_MODE_W];
      assign src = md[`CMTM_MODE_SRC_LSB +: 2];
      assign gmode = md[`CMTM_MODE_GATE_LSB +: 2];
      assign en = md[`CMTM_MODE_EN];
      assign cnt = cnt_r[i*TW +: TW];
      assign refv = ref_r[i*TW +: TW];
      assign gate_lvl = pin_s[i/2]; // RL1
      assign gate_edge = pin_fall[i/2];
      assign casc_upper = (i == 1) ? gcfg_r[`CMTM_GCFG_CASC12] :
                          (i == 3) ? gcfg_r[`CMTM_GCFG_CASC34] : 1'b0;
      // registered neighbour match avoids a combinational ring
      assign src_tick = (src == `CMTM_SRC_TIMER) ? mev_r[(i+3)%4] :
                        (src == `CMTM_SRC_SYSCLK) ? 1'b1 :
                        (src == `CMTM_SRC_DIV16) ? div16_tick :
                        pin_rise[2+i]; // RL6
      assign cnt_hold = (gmode == `CMTM_GATE_LEVEL) && !gate_lvl; // RL2
      // the lower neighbour of an upper timer is always the previous one in the ring
      assign tick = en && !cnt_hold && (casc_upper ? mev_r[(i+3)%4] : src_tick); // RL5 RL13
      assign match_ev[i] = tick && (cnt == refv); // RL3
      assign cap_ev[i] = en &&
        ((md[`CMTM_MODE_CAP_LSB + `CMTM_CAP_RISE] && pin_rise[2+i]) ||
         (md[`CMTM_MODE_CAP_LSB + `CMTM_CAP_FALL] && pin_fall[2+i])); // RL8
      assign wr_me = wr_go && wa_tmr && (wa_idx == i);

      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          mode_r[i*`CMTM_MODE_W +: `CMTM_MODE_W] <= {`CMTM_MODE_W{1'b0}};
          ref_r[i*TW +: TW] <= `CMTM_REF_RESET;
          cnt_r[i*TW +: TW] <= {TW{1'b0}};
          cap_r[i*TW +: TW] <= {TW{1'b0}};
          match_out[i] <= 1'b1;
        end
        else
        begin
          if (wr_me && wa_ofs == `CMTM_TMR_MODE_OFS)
            mode_r[i*`CMTM_MODE_W +: `CMTM_MODE_W] <= wdata_r[`CMTM_MODE_W-1:0];
          if (wr_me && wa_ofs == `CMTM_TMR_REF_OFS)
            ref_r[i*TW +: TW] <= wdata_r[TW-1:0];
          if (wr_me && wa_ofs == `CMTM_TMR_CNT_OFS)
            cnt_r[i*TW +: TW] <= wdata_r[TW-1:0];
          else if (en && gmode == `CMTM_GATE_RESTART && gate_edge)
            cnt_r[i*TW +: TW] <= {TW{1'b0}}; // RL2
          else if (match_ev[i])
            cnt_r[i*TW +: TW] <= {TW{1'b0}};
          else if (tick)
            cnt_r[i*TW +: TW] <= cnt + {{(TW-1){1'b0}}, 1'b1};
          if (cap_ev[i])
            cap_r[i*TW +: TW] <= cnt;
          // pulse mode returns high one cycle after the match
          if (match_ev[i] && md[`CMTM_MODE_TOGGLE])
            match_out[i] <= ~match_out[i]; // RL4
          else if (match_ev[i])
            match_out[i] <= 1'b0; // RL4
          else if (!md[`CMTM_MODE_TOGGLE])
            match_out[i] <= 1'b1;
        end
      end
    end

    for (i = 0; i < NBRG; i = i + 1)
    begin : g_brg
      wire [BW-1:0] bc;
      wire btick;

      assign bc = brg_cnt_r[i*BW +: BW];
      // the first generator may follow clock pin five instead of the system clock
      assign btick = (i == 0 && gcfg_r[`CMTM_GCFG_EXT_CLOCK_PIN_FIVE_EN]) ? pin_rise[6] : 1'b1; // RL9 RL10
      assign brg_wrap[i] = btick && (bc == brg_div_r[i*BW +: BW]);

      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          brg_div_r[i*BW +: BW] <= `CMTM_BRG_DIV_RESET;
          brg_cnt_r[i*BW +: BW] <= {BW{1'b0}};
          baud_gen_out[i] <= 1'b0;
        end
        else
        begin
          if (wr_go && wa == (`CMTM_BRG_BASE + i*4))
            brg_div_r[i*BW +: BW] <= wdata_r[BW-1:0];
          if (brg_wrap[i])
          begin
            brg_cnt_r[i*BW +: BW] <= {BW{1'b0}};
            baud_gen_out[i] <= ~baud_gen_out[i]; // RL12
          end
          else if (btick)
            brg_cnt_r[i*BW +: BW] <= bc + {{(BW-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  // timer clock for the system-integration timers
  always @(posedge aclk)
  begin
    if (!aresetn)
      siu_timer_tick <= 1'b0;
    else if (gcfg_r[`CMTM_GCFG_SIU_TIMER_CLOCK_PIN_SEL])
      siu_timer_tick <= pin_rise[7]; // RL11
    else
      siu_timer_tick <= brg_wrap[0] & ~baud_gen_out[0]; // RL9
  end

  // global config and sticky status, set beats clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gcfg_r <= {`CMTM_GCFG_W{1'b0}};
      stat_r <= 8'h00;
    end
    else
    begin
      if (wr_go && wa == `CMTM_GCFG_ADDR)
        gcfg_r <= wdata_r[`CMTM_GCFG_W-1:0];
      if (wr_go && wa == `CMTM_STAT_ADDR)
        stat_r <= (stat_r & ~wdata_r[7:0]) | {cap_ev, match_ev};
      else
        stat_r <= stat_r | {cap_ev, match_ev};
    end
  end

  // write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMTM_RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_have_r && !s_axi_bvalid;
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_have_r && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
        aw_have_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        // partial strobes are ignored: every field is written whole
        wdata_r <= s_axi_wdata;
        w_have_r <= 1'b1;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa < `CMTM_BRG_END) ? `CMTM_RESP_OKAY : `CMTM_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  reg [31:0] rd_mux;
  reg rd_ok;
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (ra[7:2] == `CMTM_GCFG_ADDR >> 2)
      rd_mux[`CMTM_GCFG_W-1:0] = gcfg_r;
    else if (ra[7:2] == `CMTM_STAT_ADDR >> 2)
      rd_mux[7:0] = stat_r;
    else if (ra >= `CMTM_TMR_BASE && ra < `CMTM_BRG_BASE)
    begin
      case (ra[3:2])
        2'h0: rd_mux[`CMTM_MODE_W-1:0] = mode_r[(ra[5:4]-2'h1)*`CMTM_MODE_W +: `CMTM_MODE_W];
        2'h1: rd_mux[TW-1:0] = ref_r[(ra[5:4]-2'h1)*TW +: TW];
        2'h2: rd_mux[TW-1:0] = cnt_r[(ra[5:4]-2'h1)*TW +: TW];
        default: rd_mux[TW-1:0] = cap_r[(ra[5:4]-2'h1)*TW +: TW];
      endcase
    end
    else if (ra >= `CMTM_BRG_BASE && ra < `CMTM_BRG_END)
      rd_mux[BW-1:0] = brg_div_r[ra[4:2]*BW +: BW];
    else
      rd_ok = 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CMTM_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `CMTM_RESP_OKAY : `CMTM_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cmtm_timers

// >>> cmtm_timers_monitor.sv
// bus handshake and timer tick checker for the comms timer block
`timescale 1ns/1ps
module cmtm_timers_monitor #(
  parameter NBRG = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NBRG-1:0] baud_gen_out,
  input wire siu_timer_clock_pin,
  input wire siu_timer_tick
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  reg [5:0] pin_h;
  // wide window: sync depth plus edge detect, with slack either side
  wire pin_rose = |(pin_h[4:0] & ~pin_h[5:1]);
  always @(posedge aclk)
    pin_h <= {pin_h[4:0], siu_timer_clock_pin};
  sequence s_rd_ans;
    ##1 s_axi_arready ##1 s_axi_rvalid;
  endsequence
  property p_tick_pulse;
    siu_timer_tick |=> !siu_timer_tick;
  endproperty
  property p_tick_cause;
    siu_timer_tick |-> (baud_gen_out[0] && !$past(baud_gen_out[0])) || pin_rose;
  endproperty
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  property p_rd_lat;
    $rose(s_axi_arvalid) && !s_axi_rvalid |-> s_rd_ans;
  endproperty
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
  a_tick_cause: assert property (p_tick_cause) else $error("tick without cause");
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
  a_ar_pulse: assert property (p_ar_pulse) else $error("arready held");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
  a_r_drop: assert property (p_r_drop) else $error("rvalid stuck");
endmodule // cmtm_timers_monitor
bind cmtm_timers cmtm_timers_monitor #(.NBRG(NBRG)) u_mon (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .baud_gen_out(baud_gen_out),
  .siu_timer_clock_pin(siu_timer_clock_pin),
  .siu_timer_tick(siu_timer_tick)
);

// >>> cmtm_board.sv
// board model driving the two external clock pins
`timescale 1ns/1ps
module cmtm_board (
  input wire run5,
  input wire runt,
  output logic ext_clock_pin_five = 1'b0,
  output logic siu_timer_clock_pin = 1'b0
);
  // odd half periods keep the pins unrelated to aclk; they stand low when stopped
  always #17 ext_clock_pin_five = run5 ? ~ext_clock_pin_five : 1'b0;
  always #23 siu_timer_clock_pin = runt ? ~siu_timer_clock_pin : 1'b0;
endmodule // cmtm_board

// >>> test_comm_timers_with_gate_capture.sv
// self-checking bench for the comms timer block
`timescale 1ns/1ps
module test_comm_timers_with_gate_capture;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic gate_in_a = 0, gate_in_b = 0, run5 = 0, runt = 0;
  logic [3:0] capture_in = 0;
  wire [3:0] match_out;
  wire [7:0] baud_gen_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire ext_clock_pin_five, siu_timer_clock_pin, siu_timer_tick;
  int error_cnt = 0, num_checks = 0, ticks = 0, t = 0, t0 = 0;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [7:0] acc, prev;
  cmtm_timers uut (.*);
  cmtm_board brd (.*);
  always #2.5 aclk = ~aclk;
  always @(posedge aclk)
    if (siu_timer_tick === 1'b1) ticks <= ticks + 1;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // bounded wait for a timer output to be seen low
  task wfall(input int i);
    t = 0;
    while (match_out[i] !== 1'b0 && t < 300)
    begin
      @(posedge aclk);
      t++;
    end
  endtask
  task conclude;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude;
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    chk("match idle", 32'hf, {28'h0, match_out});
    chk("gens idle", 32'h0, {24'h0, baud_gen_out});
    rd(8'h14);
    chk("ref reset", 32'hffff, rv);
    rd(8'h80);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    wr(8'h80, 32'h0);
    chk("unmapped wresp", 32'h2, {30'h0, rs});
    wr(8'h14, 32'hffff);
    chk("mapped wresp", 32'h0, {30'h0, rs});
    $display("reset test done");
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h82);
    wfall(0);
    @(posedge aclk);
    chk("pulse width", 32'h1, {31'h0, match_out[0]});
    wfall(0);
    chk("div16 period", 32'd15, t);
    rd(8'h04);
    chk("match flag", 32'h1, rv & 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h24, 32'h5);
    wr(8'h20, 32'h91);
    wfall(1);
    repeat (3) @(posedge aclk);
    chk("toggle held", 32'h0, {31'h0, match_out[1]});
    wr(8'h20, 32'h0);
    $display("output test done");
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h1);
    wr(8'h28, 32'h0);
    wr(8'h24, 32'hffff);
    wr(8'h20, 32'h80);
    wr(8'h10, 32'h81);
    repeat (40) @(posedge aclk);
    wr(8'h10, 32'h0);
    rd(8'h28);
    chk("upper count", 32'h1, {31'h0, rv > 5 && rv < 40});
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h0);
    $display("cascade test done");
    // each mode sees one rise then one fall
    for (int m = 1; m < 4; m++)
    begin
      wr(8'h30, 32'h81 | (m << 5));
      for (int e = 1; e >= 0; e--)
      begin
        wr(8'h04, 32'hff);
        capture_in[2] <= e[0];
        repeat (6) @(posedge aclk);
        rd(8'h04);
        chk("capture flag", {25'h0, m[1 - e], 6'h0}, rv & 32'h40);
      end
    end
    rd(8'h3c);
    chk("capture value", 32'h1, {31'h0, rv != 0});
    $display("capture test done");
    wr(8'h48, 32'h0);
    gate_in_a <= 1;
    wr(8'h40, 32'h85);
    repeat (10) @(posedge aclk);
    rd(8'h48);
    chk("gated stop", 32'h0, rv);
    gate_in_b <= 1;
    repeat (10) @(posedge aclk);
    rd(8'h48);
    chk("gated run", 32'h1, {31'h0, rv != 0});
    wr(8'h14, 32'hffff);
    wr(8'h10, 32'h89);
    repeat (30) @(posedge aclk);
    gate_in_a <= 0;
    repeat (5) @(posedge aclk);
    rd(8'h18);
    chk("restart", 32'h1, {31'h0, rv < 16});
    $display("gate test done");
    for (int k = 0; k < 8; k++)
      wr(8'h60 + 8'(4 * k), 32'h1);
    acc = 0;
    prev = baud_gen_out;
    repeat (8)
    begin
      @(posedge aclk);
      acc = acc | (prev ^ baud_gen_out);
      prev = baud_gen_out;
    end
    chk("gens toggle", 32'hff, {24'h0, acc});
    t0 = ticks;
    repeat (40) @(posedge aclk);
    chk("internal ticks", 32'h1, {31'h0, ticks > t0});
    // pins stopped first: the only tick source must be cut
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h00, s ? 32'h8 : 32'h4);
      repeat (10) @(posedge aclk);
      t0 = ticks;
      repeat (40) @(posedge aclk);
      chk("stopped pin ticks", 32'h0, ticks - t0);
      run5 <= !s;
      runt <= s;
      repeat (120) @(posedge aclk);
      chk("pin ticks", 32'h1, {31'h0, ticks > t0});
      run5 <= 0;
      runt <= 0;
    end
    $display("tick test done");
    conclude;
  end
endmodule // test_comm_timers_with_gate_capture
